// ---- core/fcc_ctrl.sv ----
// flash code control/status: error latch, download request and routine copy engine
`timescale 1ns/1ps
module fcc_ctrl (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // disturbance events from the system, asynchronous
  input wire logic pe_active,
  input wire logic pe_fault,
  input wire logic irq_taken,
  input wire logic flash_read,
  input wire logic sleep_exec,
  input wire logic other_master,
  // cpu state, same clock
  input wire logic exec_from_ram,
  // routine rom, data valid one cycle after address
  output logic [fcc_pkg::ROM_AW-1:0] rom_addr,
  input wire logic [31:0] rom_data,
  // on-chip ram write port
  output logic ram_we,
  output logic [fcc_pkg::RAM_AW-1:0] ram_addr,
  output logic [31:0] ram_wdata,
  // status to the flash core and cpu
  output logic pe_enable,
  output logic flash_error_flag,
  output logic dl_busy,
  output logic irq
);
  fcc_pkg::fcc_state_s s_q;
  fcc_pkg::fcc_state_s s_d;
  logic [fcc_pkg::EV_W-1:0] ev_s;
  logic pe_s;
  logic fault_s;
  logic irq_s;
  logic read_s;
  logic sleep_s;
  logic other_s;
  logic accept;
  logic wr_ccs;
  logic copy_wr;
  logic copy_ok;
  logic err_set;
  logic dl_done;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  fcc_sync #(
    .W(fcc_pkg::EV_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .d({pe_active, pe_fault, irq_taken, flash_read, sleep_exec, other_master}),
    .q(ev_s)
  );

  assign {pe_s, fault_s, irq_s, read_s, sleep_s, other_s} = ev_s;

  assign accept = hsel & htrans[1] & hready;
  assign wr_ccs = s_q.dp_wr & s_q.dp_ok & hit(s_q.dp_addr, fcc_pkg::OFS_CCS);
  assign copy_wr = wr_ccs & hwdata[fcc_pkg::CCS_COPY_BIT];
  // a request while a copy runs, or with no routine chosen, is dropped too
  assign copy_ok = !s_q.cfg[fcc_pkg::CFG_EMU_BIT]
    & (s_q.key == fcc_pkg::KEY_DL)
    & exec_from_ram
    & (s_q.dl == fcc_pkg::DL_IDLE)
    & (s_q.cfg[fcc_pkg::CFG_PCS_BIT] | s_q.cfg[fcc_pkg::CFG_ECS_BIT]);
  assign err_set = pe_s & (fault_s
    | irq_s
    | read_s
    | sleep_s
    | other_s);
  assign dl_done = (s_q.dl == fcc_pkg::DL_DATA) & (s_q.cnt == fcc_pkg::DL_LAST);

  always_comb begin
    s_d = s_q;
    s_d.ram_we = 1'b0;

    // flag only ever rises; nothing but the reset lowers it
    s_d.err = s_q.err | err_set;

    // bus address phase; word access or byte access to lane 0 only
    s_d.dp_wr = accept & hwrite;
    s_d.dp_rd = accept & !hwrite;
    s_d.dp_addr = haddr[7:0];
    s_d.dp_ok = (haddr[1:0] == 2'h0)
      & ((hsize == fcc_pkg::HSIZE_BYTE) | (hsize == fcc_pkg::HSIZE_WORD));
    s_d.hresp = 1'b0;
    s_d.hready = 1'b1;
    // one wait state on reads so a write just before is already visible
    if (accept & !hwrite) begin
      s_d.hready = 1'b0;
    end

    // read data formed in the wait state
    if (s_q.dp_rd) begin
      s_d.hrdata = 32'h0;
      if (s_q.dp_ok) begin
        unique case (1'b1)
          hit(s_q.dp_addr, fcc_pkg::OFS_CCS): begin
            // request bit and bits 3..1 read as zero
            s_d.hrdata[7:0] = fcc_pkg::CCS_FIXED;
            s_d.hrdata[fcc_pkg::CCS_ERR_BIT] = s_q.err;
          end
          hit(s_q.dp_addr, fcc_pkg::OFS_KEY): begin
            s_d.hrdata[7:0] = s_q.key;
          end
          hit(s_q.dp_addr, fcc_pkg::OFS_CFG): begin
            s_d.hrdata[7:0] = s_q.cfg;
          end
          hit(s_q.dp_addr, fcc_pkg::OFS_IST): begin
            s_d.hrdata[1:0] = s_q.ist;
          end
          hit(s_q.dp_addr, fcc_pkg::OFS_IMSK): begin
            s_d.hrdata[1:0] = s_q.imsk;
          end
          hit(s_q.dp_addr, fcc_pkg::OFS_STAT): begin
            s_d.hrdata[2:0] = {s_q.pe_en, s_q.copy, s_q.err};
          end
          default: begin
            s_d.hrdata = 32'h0;
          end
        endcase
      end
    end

    // register writes in the data phase
    if (s_q.dp_wr & s_q.dp_ok) begin
      if (hit(s_q.dp_addr, fcc_pkg::OFS_KEY)) begin
        s_d.key = hwdata[7:0];
      end
      if (hit(s_q.dp_addr, fcc_pkg::OFS_CFG)) begin
        s_d.cfg = hwdata[7:0] & fcc_pkg::CFG_MASK;
      end
      if (hit(s_q.dp_addr, fcc_pkg::OFS_IMSK)) begin
        s_d.imsk = hwdata[1:0];
      end
      if (hit(s_q.dp_addr, fcc_pkg::OFS_IST)) begin
        s_d.ist = s_q.ist & ~hwdata[1:0];
      end
    end

    // download request; a failed condition leaves everything as it was
    if (copy_wr & copy_ok) begin
      s_d.copy = 1'h1;
      s_d.dl = fcc_pkg::DL_ADDR;
      s_d.cnt = '0;
      // program routine wins when both are chosen
      s_d.rom_addr = {!s_q.cfg[fcc_pkg::CFG_PCS_BIT], {fcc_pkg::DL_CNT_W{1'b0}}};
    end

    // copy engine, two cycles per word
    unique case (s_q.dl)
      fcc_pkg::DL_IDLE: begin
      end
      fcc_pkg::DL_ADDR: begin
        s_d.dl = fcc_pkg::DL_DATA;
      end
      fcc_pkg::DL_DATA: begin
        s_d.ram_we = 1'b1;
        s_d.ram_addr = {s_q.cfg[fcc_pkg::CFG_TDA_LSB +: fcc_pkg::TDA_W], s_q.cnt};
        s_d.ram_wdata = rom_data;
        if (dl_done) begin
          s_d.dl = fcc_pkg::DL_IDLE;
          s_d.copy = 1'h0;
          s_d.cfg[fcc_pkg::CFG_PCS_BIT] = 1'b0;
          s_d.cfg[fcc_pkg::CFG_ECS_BIT] = 1'b0;
        end else begin
          s_d.dl = fcc_pkg::DL_ADDR;
          s_d.cnt = s_q.cnt + 1'b1;
          s_d.rom_addr = {s_q.rom_addr[fcc_pkg::DL_CNT_W], s_q.cnt + 1'b1};
        end
      end
      // the unused code falls back to idle rather than locking the engine
      default: begin
        s_d.dl = fcc_pkg::DL_IDLE;
      end
    endcase

    // sticky events; a new event beats a clear in the same cycle
    if (err_set & !s_q.err) begin
      s_d.ist[fcc_pkg::IRQ_ERR_BIT] = 1'b1;
    end
    if (dl_done) begin
      s_d.ist[fcc_pkg::IRQ_DONE_BIT] = 1'b1;
    end
    s_d.irq = |(s_d.ist & s_d.imsk);

    // flash core may program or erase only with key 5a, no error, no copy
    s_d.pe_en = (s_d.key == fcc_pkg::KEY_PE) & !s_d.err
      & (s_d.dl == fcc_pkg::DL_IDLE);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.key <= fcc_pkg::KEY_RESET;
      s_q.cfg <= fcc_pkg::CFG_RESET;
      s_q.ist <= fcc_pkg::IRQ_RESET;
      s_q.imsk <= fcc_pkg::IRQ_RESET;
      s_q.dl <= fcc_pkg::DL_IDLE;
      s_q.hready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata = s_q.hrdata;
  assign hreadyout = s_q.hready;
  assign hresp = s_q.hresp;
  assign rom_addr = s_q.rom_addr;
  assign ram_we = s_q.ram_we;
  assign ram_addr = s_q.ram_addr;
  assign ram_wdata = s_q.ram_wdata;
  assign pe_enable = s_q.pe_en;
  assign flash_error_flag = s_q.err;
  assign dl_busy = s_q.copy;
  assign irq = s_q.irq;

  // checks next to the logic they guard
  a_err_fault: assert property (@(posedge ref_clk) disable iff (!nrst)
    pe_s && fault_s |=> flash_error_flag)
    else $error("fault during program/erase did not set error flag");

  a_err_irq: assert property (@(posedge ref_clk) disable iff (!nrst)
    pe_s && irq_s |=> flash_error_flag ##1 !pe_enable)
    else $error("interrupt during program/erase did not set error flag");

  a_err_read: assert property (@(posedge ref_clk) disable iff (!nrst)
    pe_s && read_s |=> flash_error_flag)
    else $error("flash read during program/erase did not set error flag");

  a_err_sleep: assert property (@(posedge ref_clk) disable iff (!nrst)
    pe_s && sleep_s |=> flash_error_flag)
    else $error("sleep during program/erase did not set error flag");

  a_err_master: assert property (@(posedge ref_clk) disable iff (!nrst)
    pe_s && other_s |=> flash_error_flag)
    else $error("other master during program/erase did not set error flag");

  a_ccs_reserved: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_q.dp_rd && s_q.dp_ok && hit(s_q.dp_addr, fcc_pkg::OFS_CCS)
      |=> hreadyout && hrdata[3:1] == 3'h0 && hrdata[7] && hrdata[4] == $past(s_q.err))
    else $error("reserved status bits not read as documented");

  a_copy_readzero: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_q.dp_rd && hit(s_q.dp_addr, fcc_pkg::OFS_CCS) |=> hrdata[0] == 1'b0)
    else $error("request bit read back non-zero");

  a_dl_start: assert property (@(posedge ref_clk) disable iff (!nrst)
    copy_wr && copy_ok |=> dl_busy ##2 ram_we
      && ram_addr == {s_q.cfg[fcc_pkg::CFG_TDA_LSB +: fcc_pkg::TDA_W], {fcc_pkg::DL_CNT_W{1'b0}}})
    else $error("accepted request did not start the copy");

  a_dl_refuse: assert property (@(posedge ref_clk) disable iff (!nrst)
    copy_wr && !dl_busy && (s_q.key != fcc_pkg::KEY_DL || !exec_from_ram
      || s_q.cfg[fcc_pkg::CFG_EMU_BIT]) |=> !dl_busy ##1 !ram_we)
    else $error("request taken although a condition failed");

  a_dl_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
    $fell(dl_busy) |-> $past(dl_done) && ram_we)
    else $error("request bit cleared other than at copy end");

  a_dl_length: assert property (@(posedge ref_clk) disable iff (!nrst)
    copy_wr && copy_ok |=> dl_busy [*8] ##24 dl_busy ##1 !dl_busy)
    else $error("copy did not take its full length");

  a_err_sticky: assert property (@(posedge ref_clk) disable iff (!nrst)
    flash_error_flag |=> flash_error_flag)
    else $error("error flag cleared without reset");

  a_err_block: assert property (@(posedge ref_clk) disable iff (!nrst)
    flash_error_flag |=> !pe_enable)
    else $error("program/erase enabled while error flag set");

  // bus timing, copy engine and event checks
  a_err_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
    !pe_s && !flash_error_flag |=> !flash_error_flag)
    else $error("error flag set with no program/erase running");

  a_err_event: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(flash_error_flag) |-> s_q.ist[fcc_pkg::IRQ_ERR_BIT])
    else $error("error flag rose without its status event");

  a_read_wait: assert property (@(posedge ref_clk) disable iff (!nrst)
    accept && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read did not take exactly one wait state");

  a_write_nowait: assert property (@(posedge ref_clk) disable iff (!nrst)
    accept && hwrite |=> hreadyout)
    else $error("write inserted a wait state");

  a_copy_nosel: assert property (@(posedge ref_clk) disable iff (!nrst)
    copy_wr && !dl_busy && !s_q.cfg[fcc_pkg::CFG_PCS_BIT] && !s_q.cfg[fcc_pkg::CFG_ECS_BIT] |=> !dl_busy)
    else $error("request taken with no routine chosen");

  a_copy_first: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(dl_busy) |-> rom_addr == {!s_q.cfg[fcc_pkg::CFG_PCS_BIT], {fcc_pkg::DL_CNT_W{1'h0}}})
    else $error("copy did not start at word zero of the chosen routine");

  a_ram_pulse: assert property (@(posedge ref_clk) disable iff (!nrst)
    ram_we |=> !ram_we)
    else $error("ram write strobe held longer than one cycle");

  a_copy_blocks_pe: assert property (@(posedge ref_clk) disable iff (!nrst)
    dl_busy |-> !pe_enable)
    else $error("program/erase enabled while a copy runs");

  a_select_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
    $fell(dl_busy) |-> !s_q.cfg[fcc_pkg::CFG_PCS_BIT] && !s_q.cfg[fcc_pkg::CFG_ECS_BIT])
    else $error("routine select not cleared at copy end");

  a_copy_event: assert property (@(posedge ref_clk) disable iff (!nrst)
    $fell(dl_busy) |-> s_q.ist[fcc_pkg::IRQ_DONE_BIT])
    else $error("copy end did not raise its status event");
endmodule // fcc_ctrl

// ---- core/fcc_pkg.sv ----
// shared constants and types of the flash code control/status block
package fcc_pkg;
  // register byte offsets, decoded on haddr[7:0]
  localparam logic [7:0] OFS_CCS = 8'h00;
  localparam logic [7:0] OFS_KEY = 8'h04;
  localparam logic [7:0] OFS_CFG = 8'h08;
  localparam logic [7:0] OFS_IST = 8'h0c;
  localparam logic [7:0] OFS_IMSK = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  // code_control_status fields
  localparam int CCS_ERR_BIT = 4;
  localparam int CCS_COPY_BIT = 0;
  localparam logic [7:0] CCS_FIXED = 8'h80;
  // key codes
  localparam logic [7:0] KEY_DL = 8'ha5;
  localparam logic [7:0] KEY_PE = 8'h5a;
  localparam logic [7:0] KEY_RESET = 8'h00;
  // configuration fields
  localparam int CFG_EMU_BIT = 0;
  localparam int CFG_PCS_BIT = 1;
  localparam int CFG_ECS_BIT = 2;
  localparam int CFG_TDA_LSB = 4;
  localparam logic [7:0] CFG_MASK = 8'h77;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // interrupt status / mask fields
  localparam int IRQ_ERR_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  // download engine sizes
  localparam int DL_CNT_W = 4;
  localparam logic [DL_CNT_W-1:0] DL_LAST = 4'hf;
  localparam int TDA_W = 3;
  localparam int ROM_AW = DL_CNT_W + 1;
  localparam int RAM_AW = TDA_W + DL_CNT_W;
  // bus encodings
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int EV_W = 6;

  typedef enum logic [1:0] {DL_IDLE, DL_ADDR, DL_DATA} fcc_dl_e;

  typedef struct packed {
    logic err;
    logic copy;
    logic [7:0] key;
    logic [7:0] cfg;
    logic [1:0] ist;
    logic [1:0] imsk;
    fcc_dl_e dl;
    logic [DL_CNT_W-1:0] cnt;
    logic [ROM_AW-1:0] rom_addr;
    logic ram_we;
    logic [RAM_AW-1:0] ram_addr;
    logic [31:0] ram_wdata;
    logic dp_wr;
    logic dp_rd;
    logic dp_ok;
    logic [7:0] dp_addr;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic irq;
    logic pe_en;
  } fcc_state_s;
endpackage

// ---- core/fcc_sync.sv ----
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module fcc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } fcc_sync_s;

  fcc_sync_s s_q;
  fcc_sync_s s_d;

  // first stage feeds only the second stage
  always_comb begin
    s_d.meta = d;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.stable;
endmodule // fcc_sync

// ---- testbench/fcc_sys_model.sv ----
// system-side model: routine rom with one-cycle latency and a capturing on-chip ram
`timescale 1ns/1ps
module fcc_sys_model (
  // clock
  input wire logic ref_clk,
  // routine rom
  input wire logic [fcc_pkg::ROM_AW-1:0] rom_addr,
  output logic [31:0] rom_data,
  // on-chip ram write port
  input wire logic ram_we,
  input wire logic [fcc_pkg::RAM_AW-1:0] ram_addr,
  input wire logic [31:0] ram_wdata
);
  logic [31:0] ram_mem [0:(1<<fcc_pkg::RAM_AW)-1];
  int wr_count = 0;
  initial rom_data = 32'h0;
  // rom word carries its own address so a misplaced copy shows up
  always @(posedge ref_clk) begin
    rom_data <= {16'hc0de, 11'h0, rom_addr};
    if (ram_we) begin
      ram_mem[ram_addr] <= ram_wdata;
      wr_count <= wr_count + 1;
    end
  end
endmodule // fcc_sys_model

// ---- testbench/flash_code_ctrl_status_bench.sv ----
// self-checking bench of the flash code control/status block
`timescale 1ns/1ps
module flash_code_ctrl_status_bench;
  logic ref_clk = 1'b0, nrst = 1'b0, hsel = 1'b1, hwrite = 1'b0, pe_act = 1'b0, efr = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd_v;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [4:0] ev = 5'h0;
  logic [31:0] hrdata, rom_data, ram_wdata;
  logic hreadyout, hresp, ram_we, pe_enable, flag, dl_busy, irq;
  logic [fcc_pkg::ROM_AW-1:0] rom_addr;
  logic [fcc_pkg::RAM_AW-1:0] ram_addr;
  int fail_count = 0, checks = 0, cyc = 0, n0;
  logic [7:0] rcfg [0:3] = '{8'h33, 8'h32, 8'h32, 8'h30};
  logic [7:0] rkey [0:3] = '{8'ha5, 8'h00, 8'ha5, 8'ha5};

  fcc_ctrl fcc_ctrl_i (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pe_active(pe_act), .pe_fault(ev[0]), .irq_taken(ev[1]),
    .flash_read(ev[2]), .sleep_exec(ev[3]), .other_master(ev[4]), .exec_from_ram(efr),
    .rom_addr(rom_addr), .rom_data(rom_data), .ram_we(ram_we), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .pe_enable(pe_enable), .flash_error_flag(flag), .dl_busy(dl_busy), .irq(irq));
  fcc_sys_model fcc_sys_model_i (.ref_clk(ref_clk), .rom_addr(rom_addr), .rom_data(rom_data),
    .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata));

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  task finish_test;
    $display("checks %0d errors %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  task chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask

  // hready is sampled before the edge since every design output is a flop
  task wait_ready;
    logic r;
    do begin
      @(negedge ref_clk);
      r = hreadyout;
      rd_v = hrdata;
      @(posedge ref_clk);
    end while (r !== 1'b1);
  endtask

  // entered just after a rising edge, returns just after one
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= fcc_pkg::HSIZE_WORD;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_ready();
  endtask

  task rd_chk(input string n, input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(n, {24'h0, exp}, rd_v);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task do_reset;
    nrst <= 1'b0;
    ev <= 5'h0;
    pe_act <= 1'b0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
  endtask

  task wait_idle;
    int n;
    n = 0;
    @(negedge ref_clk);
    while (dl_busy && n < 200) begin
      n++;
      @(negedge ref_clk);
    end
    // the last word lands in the model at the edge after the flag falls
    @(posedge ref_clk);
    @(posedge ref_clk);
  endtask

  initial begin
    do_reset();
    rd_chk("ccs reset", fcc_pkg::OFS_CCS, 8'h80);
    rd_chk("key reset", fcc_pkg::OFS_KEY, 8'h00);
    rd_chk("unmapped", 8'h3c, 8'h00);
    bus(1'b1, fcc_pkg::OFS_CCS, 8'h0e);
    rd_chk("ccs reserved", fcc_pkg::OFS_CCS, 8'h80);
    ev <= 5'h1f;
    repeat (6) @(posedge ref_clk);
    ev <= 5'h0;
    chk("flag idle", 32'h0, {31'h0, flag});
    // each setting condition but the idle copy engine broken in turn
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, fcc_pkg::OFS_CFG, rcfg[k]);
      bus(1'b1, fcc_pkg::OFS_KEY, rkey[k]);
      efr <= (k != 2);
      n0 = fcc_sys_model_i.wr_count;
      bus(1'b1, fcc_pkg::OFS_CCS, 8'h01);
      repeat (3) @(posedge ref_clk);
      chk("refused busy", 32'h0, {31'h0, dl_busy});
      chk("refused copies", n0, fcc_sys_model_i.wr_count);
    end
    bus(1'b1, fcc_pkg::OFS_IMSK, 8'h02);
    for (int j = 0; j < 2; j++) begin
      bus(1'b1, fcc_pkg::OFS_CFG, j ? 8'h44 : 8'h32);
      bus(1'b1, fcc_pkg::OFS_KEY, 8'ha5);
      efr <= 1'b1;
      ev <= 5'h0;
      n0 = fcc_sys_model_i.wr_count;
      // vector base sits outside this block and is already zero here
      bus(1'b1, fcc_pkg::OFS_CCS, 8'h01);
      rd_chk("dummy read 1", fcc_pkg::OFS_CCS, 8'h80);
      rd_chk("dummy read 2", fcc_pkg::OFS_CCS, 8'h80);
      rd_chk("stat busy", fcc_pkg::OFS_STAT, 8'h02);
      chk("copy busy", 32'h1, {31'h0, dl_busy});
      wait_idle();
      chk("copy done", 32'h0, {31'h0, dl_busy});
      chk("copy words", n0 + 16, fcc_sys_model_i.wr_count);
      chk("last word", {16'hc0de, 11'h0, j[0], 4'hf}, fcc_sys_model_i.ram_mem[{j ? 3'h4 : 3'h3, 4'hf}]);
      rd_chk("select cleared", fcc_pkg::OFS_CFG, j ? 8'h40 : 8'h30);
      chk("done irq", 32'h1, {31'h0, irq});
      bus(1'b1, fcc_pkg::OFS_IST, 8'h02);
      @(posedge ref_clk);
      chk("done irq clear", 32'h0, {31'h0, irq});
    end
    // one disturbance kind per run, since only reset clears the flag
    for (int i = 0; i < 5; i++) begin
      do_reset();
      bus(1'b1, fcc_pkg::OFS_KEY, 8'h5a);
      bus(1'b1, fcc_pkg::OFS_IMSK, 8'h01);
      pe_act <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk("pe enable", 32'h1, {31'h0, pe_enable});
      ev <= 5'h1 << i;
      repeat (6) @(posedge ref_clk);
      ev <= 5'h0;
      chk("flag", 32'h1, {31'h0, flag});
      chk("pe blocked", 32'h0, {31'h0, pe_enable});
      bus(1'b1, fcc_pkg::OFS_CCS, 8'h00);
      rd_chk("ccs error", fcc_pkg::OFS_CCS, 8'h90);
      rd_chk("stat error", fcc_pkg::OFS_STAT, 8'h01);
      chk("err irq", 32'h1, {31'h0, irq});
      bus(1'b1, fcc_pkg::OFS_IMSK, 8'h00);
      @(posedge ref_clk);
      chk("err irq masked", 32'h0, {31'h0, irq});
    end
    finish_test();
  end
endmodule // flash_code_ctrl_status_bench
